// ### hdl/fault_pkg.sv
// Constants, codes and input bundle for the machine fault supervisor.
// Assumes a single 20 MHz clock and digitised status inputs.
`default_nettype none

package fault_pkg;

	// ********************************************************
	// Time base
	// ********************************************************
	localparam int CLK_HZ     = 20_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;

	// ********************************************************
	// Monitor times, in milliseconds
	// ********************************************************
	localparam int T_XFER_MS  = 60;
	localparam int T_LOCK_MS  = 2000;
	localparam int T_FAN_MS   = 5000;
	localparam int T_ENC_MS   = 3000;
	localparam int T_COLL_MS  = 1000;
	localparam int T_LIFT_MS  = 10000;
	localparam int T_LOWER_MS = 1500;
	localparam int T_LCT_MS   = 10000;

	// Every time converts exactly to whole cycles
	localparam int CYC_XFER  = T_XFER_MS * CYC_PER_MS;
	localparam int CYC_LOCK  = T_LOCK_MS * CYC_PER_MS;
	localparam int CYC_FAN   = T_FAN_MS * CYC_PER_MS;
	localparam int CYC_ENC   = T_ENC_MS * CYC_PER_MS;
	localparam int CYC_COLL  = T_COLL_MS * CYC_PER_MS;
	localparam int CYC_LIFT  = T_LIFT_MS * CYC_PER_MS;
	localparam int CYC_LOWER = T_LOWER_MS * CYC_PER_MS;
	localparam int CYC_LCT   = T_LCT_MS * CYC_PER_MS;

	// ********************************************************
	// Tray overload and fault codes
	// ********************************************************
	localparam int       TRAYS          = 2;
	localparam int       REINSERT_COUNT = 3;
	localparam int       SOURCES        = 11;
	localparam int       CODE_W         = 10;
	localparam logic [1:0] OVL_CNT_RST  = 2'h0;
	localparam logic [CODE_W-1:0] CODE_RST = 10'h000;

	// Source index order is also priority order, lowest first
	localparam int SRC_401 = 0;
	localparam int SRC_402 = 1;
	localparam int SRC_430 = 2;
	localparam int SRC_440 = 3;
	localparam int SRC_441 = 4;
	localparam int SRC_490 = 5;
	localparam int SRC_495 = 6;
	localparam int SRC_496 = 7;
	localparam int SRC_497 = 8;
	localparam int SRC_T1  = 9;

	localparam logic [SOURCES-1:0][CODE_W-1:0] CODE_TBL = {
		10'h1F6, 10'h1F5, 10'h1F1, 10'h1F0, 10'h1EF, 10'h1EA,
		10'h1B9, 10'h1B8, 10'h1AE, 10'h192, 10'h191
	};

	// Status inputs, all from outside the clock domain
	typedef struct packed {
		logic       xfer_on;
		logic       fb_over_4v;
		logic       fb_absent;
		logic       pwm24_on;
		logic       apc_done;
		logic       drum_over_400;
		logic       main_on;
		logic       main_lock;
		logic       dev_on;
		logic       dev_lock;
		logic       fan_on;
		logic       fan_lock;
		logic       encoder;
		logic       door_closed;
		logic       bottle_set;
		logic       coll_conn;
		logic [1:0] lift_up;
		logic [1:0] lift_sense;
		logic [1:0] lowering;
		logic [1:0] tray_set;
		logic [1:0] overload;
		logic       lct_lowering;
		logic       lct_limit;
	} status_in_t;

	localparam status_in_t STATUS_RST = '0;

endpackage : fault_pkg

`default_nettype wire

// ### hdl/hold_timer.sv
// Condition timer: expires when run has held for LIMIT cycles.
// Assumes run comes from logic on the same clock.
`default_nettype none

module hold_timer #(
	parameter int LIMIT = 1
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic run,
	output logic      expired
);

	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LAST = W'(LIMIT - 1);

	if (LIMIT < 1) begin : g_bad
		$error("hold_timer LIMIT must be at least one");
	end

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// Saturates on expiry so the fault stays asserted
	assign expired = run && (cnt_r == LAST);

	// Restart whenever the watched condition drops
	always_comb begin
		cnt_nxt = cnt_r;
		if (!run) begin
			cnt_nxt = '0;
		end else if (!expired) begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_timer_restart: assert property (!run |=> cnt_r == '0)
		else $error("timer did not restart when condition cleared");

endmodule : hold_timer

`default_nettype wire

// ### hdl/machine_fault_supervisor.sv
// Fault supervisor: timed monitors latch one service call code.
// Assumes all status inputs are asynchronous pins; rst is power-on.
//
// Functional notes
// - Transfer on and feedback over 4 V for 60 ms raises 401.
// - Transfer on at 24% drive, no feedback for 60 ms, raises 402.
// - Drum potential beyond -400 V at process init done raises 430.
// - Main motor on with lock low for 2 s raises 440.
// - Development motor on with lock high for 2 s raises 441.
// - Main fan on with lock high for 5 s raises 490.
// - Main motor on, encoder unchanged for 3 s, raises 495.
// - Door closed with collection bottle switch off raises 496.
// - Collection motor connector off for 1 s raises 497.
// - Lift sensor not active 10 s into lifting raises 501 or 502.
// - Lift sensor still on 1.5 s into lowering raises tray code.
// - Tray 1 large capacity lower limit missed in 10 s raises 501.
// - Overload asks operator reset; tray code after third reinsertion.
// - Power-on reset clears the reinsertion counter.
`default_nettype none

module machine_fault_supervisor #(
	parameter int CYC_XFER  = fault_pkg::CYC_XFER,
	parameter int CYC_LOCK  = fault_pkg::CYC_LOCK,
	parameter int CYC_FAN   = fault_pkg::CYC_FAN,
	parameter int CYC_ENC   = fault_pkg::CYC_ENC,
	parameter int CYC_COLL  = fault_pkg::CYC_COLL,
	parameter int CYC_LIFT  = fault_pkg::CYC_LIFT,
	parameter int CYC_LOWER = fault_pkg::CYC_LOWER,
	parameter int CYC_LCT   = fault_pkg::CYC_LCT
) (
	input  wire logic                           mclk,
	input  wire logic                           rst,
	input  wire fault_pkg::status_in_t          status,
	output logic                                fault_valid,
	output logic [fault_pkg::CODE_W-1:0]        service_call_code,
	output logic [fault_pkg::TRAYS-1:0]         tray_reset_req
);

	// ********************************************************
	// Input synchronisers and previous-value stage
	// ********************************************************
	fault_pkg::status_in_t sync1_r;
	fault_pkg::status_in_t sync1_nxt;
	fault_pkg::status_in_t s_r;
	fault_pkg::status_in_t s_nxt;
	fault_pkg::status_in_t prev_r;
	fault_pkg::status_in_t prev_nxt;

	// Two flops per pin; prev_r only ever sees the second stage
	always_comb begin
		sync1_nxt = status;
		s_nxt     = sync1_r;
		prev_nxt  = s_r;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_r <= fault_pkg::STATUS_RST;
			s_r     <= fault_pkg::STATUS_RST;
			prev_r  <= fault_pkg::STATUS_RST;
		end else begin
			sync1_r <= sync1_nxt;
			s_r     <= s_nxt;
			prev_r  <= prev_nxt;
		end
	end

	// ********************************************************
	// Timed monitors and the untimed 430 and 496 checks
	// ********************************************************
	logic [fault_pkg::SOURCES-1:0] hit;
	logic run_401, run_402, run_440, run_441, run_490, run_495, run_497;
	logic run_lct, lct_exp;
	logic enc_change;

	// Enables gate each run term but 497's, so an enable drop restarts the timer
	assign run_401 = s_r.xfer_on && s_r.fb_over_4v;
	assign run_402 = s_r.xfer_on && s_r.pwm24_on && s_r.fb_absent;
	assign run_440 = s_r.main_on && !s_r.main_lock;
	assign run_441 = s_r.dev_on && s_r.dev_lock;
	assign run_490 = s_r.fan_on && s_r.fan_lock;
	assign enc_change = s_r.encoder != prev_r.encoder;
	assign run_495 = s_r.main_on && !enc_change;
	assign run_497 = !s_r.coll_conn;
	assign run_lct = s_r.lct_lowering && !s_r.lct_limit;

	hold_timer #(.LIMIT(CYC_XFER)) u_t401 (
		.mclk(mclk), .rst(rst), .run(run_401), .expired(hit[fault_pkg::SRC_401])
	);
	hold_timer #(.LIMIT(CYC_XFER)) u_t402 (
		.mclk(mclk), .rst(rst), .run(run_402), .expired(hit[fault_pkg::SRC_402])
	);
	hold_timer #(.LIMIT(CYC_LOCK)) u_t440 (
		.mclk(mclk), .rst(rst), .run(run_440), .expired(hit[fault_pkg::SRC_440])
	);
	hold_timer #(.LIMIT(CYC_LOCK)) u_t441 (
		.mclk(mclk), .rst(rst), .run(run_441), .expired(hit[fault_pkg::SRC_441])
	);
	hold_timer #(.LIMIT(CYC_FAN)) u_t490 (
		.mclk(mclk), .rst(rst), .run(run_490), .expired(hit[fault_pkg::SRC_490])
	);
	hold_timer #(.LIMIT(CYC_ENC)) u_t495 (
		.mclk(mclk), .rst(rst), .run(run_495), .expired(hit[fault_pkg::SRC_495])
	);
	hold_timer #(.LIMIT(CYC_COLL)) u_t497 (
		.mclk(mclk), .rst(rst), .run(run_497), .expired(hit[fault_pkg::SRC_497])
	);
	hold_timer #(.LIMIT(CYC_LCT)) u_tlct (
		.mclk(mclk), .rst(rst), .run(run_lct), .expired(lct_exp)
	);

	// Sampled at the rising edge of the init-done strobe only
	assign hit[fault_pkg::SRC_430] = s_r.apc_done && !prev_r.apc_done
		&& s_r.drum_over_400;
	// Level check, no delay is given for the bottle switch
	assign hit[fault_pkg::SRC_496] = s_r.door_closed && !s_r.bottle_set;

	// ********************************************************
	// Per-tray lift, lower and overload monitors
	// ********************************************************
	logic [fault_pkg::TRAYS-1:0] ovl_req_r;

	for (genvar t = 0; t < fault_pkg::TRAYS; t++) begin : g_tray
		logic       lift_exp;
		logic       lower_exp;
		logic       ins;
		logic       ovl_hit;
		logic       req_nxt;
		logic [1:0] cnt_r;
		logic [1:0] cnt_nxt;

		hold_timer #(.LIMIT(CYC_LIFT)) u_lift (
			.mclk(mclk), .rst(rst),
			.run(s_r.lift_up[t] && !s_r.lift_sense[t]),
			.expired(lift_exp)
		);
		hold_timer #(.LIMIT(CYC_LOWER)) u_lower (
			.mclk(mclk), .rst(rst),
			.run(s_r.lowering[t] && s_r.lift_sense[t]),
			.expired(lower_exp)
		);

		// Insertion is the rising edge of the tray-set input
		assign ins = s_r.tray_set[t] && !prev_r.tray_set[t];
		assign ovl_hit = ins && s_r.overload[t] && ovl_req_r[t]
			&& (cnt_r == 2'(fault_pkg::REINSERT_COUNT - 1));

		// First overload only asks for a reset; later ones count
		always_comb begin
			req_nxt = ovl_req_r[t];
			cnt_nxt = cnt_r;
			if (ins && s_r.overload[t]) begin
				req_nxt = 1'b1;
				if (ovl_req_r[t] && !ovl_hit) begin
					cnt_nxt = cnt_r + 2'h1;
				end
			end else if (ins) begin
				req_nxt = 1'b0;
			end
		end

		// Count survives good insertions; only power-on clears it
		always_ff @(posedge mclk) begin
			if (rst) begin
				ovl_req_r[t] <= 1'b0;
				cnt_r        <= fault_pkg::OVL_CNT_RST;
			end else begin
				ovl_req_r[t] <= req_nxt;
				cnt_r        <= cnt_nxt;
			end
		end

		if (t == 0) begin : g_t1
			assign hit[fault_pkg::SRC_T1] = lift_exp || lower_exp
				|| ovl_hit || lct_exp;
		end else begin : g_tn
			assign hit[fault_pkg::SRC_T1 + t] = lift_exp || lower_exp
				|| ovl_hit;
		end
	end

	assign tray_reset_req = ovl_req_r;

	// ********************************************************
	// Fault latch
	// ********************************************************
	logic                         fault_r;
	logic                         fault_nxt;
	logic [fault_pkg::CODE_W-1:0] code_r;
	logic [fault_pkg::CODE_W-1:0] code_nxt;

	// Scan down so the lowest index is the one that sticks
	always_comb begin
		fault_nxt = fault_r;
		code_nxt  = code_r;
		if (!fault_r) begin
			for (int i = fault_pkg::SOURCES - 1; i >= 0; i--) begin
				if (hit[i]) begin
					fault_nxt = 1'b1;
					code_nxt  = fault_pkg::CODE_TBL[i];
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			fault_r <= 1'b0;
			code_r  <= fault_pkg::CODE_RST;
		end else begin
			fault_r <= fault_nxt;
			code_r  <= code_nxt;
		end
	end

	assign fault_valid       = fault_r;
	assign service_call_code = code_r;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_clear_lock_low;
		!fault_r && s_r.main_on && !s_r.main_lock;
	endsequence

	// Lock timer expired with no higher-priority source pending
	sequence s_lock_expired;
		hit[fault_pkg::SRC_440] && hit[2:0] == 3'h0;
	endsequence

	chk_fault_sticky: assert property (
		fault_r |=> fault_r && $stable(code_r))
		else $error("latched fault code changed");
	chk_code_401: assert property (
		!fault_r && hit[fault_pkg::SRC_401] |=> code_r == 10'h191)
		else $error("feedback-high fault did not latch 401");
	chk_main_lock: assert property (
		hit[fault_pkg::SRC_440] |-> s_r.main_on && !s_r.main_lock)
		else $error("main lock fault without low lock");
	chk_first_lock: assert property (
		s_clear_lock_low and s_lock_expired |=> code_r == 10'h1B8)
		else $error("main lock fault did not latch 440");
	chk_dev_lock: assert property (
		hit[fault_pkg::SRC_441] |-> s_r.dev_on && s_r.dev_lock)
		else $error("development lock fault with wrong polarity");
	chk_fan_lock: assert property (
		hit[fault_pkg::SRC_490] |-> s_r.fan_on && s_r.fan_lock)
		else $error("fan fault without fan lock");
	chk_encoder: assert property (
		enc_change |-> !hit[fault_pkg::SRC_495])
		else $error("encoder fault despite encoder change");
	chk_bottle: assert property (
		!fault_r && s_r.door_closed && !s_r.bottle_set
		|=> fault_r && code_r != fault_pkg::CODE_RST)
		else $error("bottle missing with door closed not flagged");
	chk_apc_check: assert property (
		!fault_r && $rose(s_r.apc_done) && s_r.drum_over_400
		&& hit[2:0] == 3'h4 |=> code_r == 10'h1AE)
		else $error("drum potential fault did not latch 430");
	chk_overload_req: assert property (
		$rose(s_r.tray_set[0]) && s_r.overload[0] |=> tray_reset_req[0])
		else $error("overload did not request tray reset");

endmodule : machine_fault_supervisor

`default_nettype wire

// ### testbench/status_model.sv
// Far-side plant model: motors, fans, sensors and switches of the engine.
// Assumes the bench changes mode and tray_in at falling edges only.
`default_nettype none

module status_model (
	input  wire logic                  mclk,
	input  wire logic [3:0]            mode,
	input  wire logic [1:0]            tray_in,
	output var  fault_pkg::status_in_t status
);
	timeunit 1ns;
	timeprecision 1ns;

	// ********************************************************
	// Plant behaviour
	// ********************************************************
	fault_pkg::status_in_t s;
	logic                  enc_r = 1'b0;

	initial status = fault_pkg::STATUS_RST;

	// Healthy plant unless mode breaks one check, or two (401 and 402) in mode F; rising-edge drive
	// keeps clear of the bench writing mode at the falling edge
	always @(posedge mclk) begin
		s = fault_pkg::STATUS_RST;
		s.door_closed = 1'b1;
		s.bottle_set = (mode != 4'h8);
		s.coll_conn = (mode != 4'h9);
		s.main_lock = (mode != 4'h4);
		s.xfer_on = (mode == 4'h1) || (mode == 4'h2) || (mode == 4'hF);
		s.fb_over_4v = (mode == 4'h1) || (mode == 4'hF);
		s.fb_absent = (mode == 4'h2) || (mode == 4'hF);
		s.pwm24_on = s.fb_absent;
		s.apc_done = (mode == 4'h3);
		s.drum_over_400 = (mode == 4'h3);
		s.main_on = (mode == 4'h4) || (mode == 4'h7);
		s.dev_on = (mode == 4'h5);
		s.dev_lock = (mode == 4'h5);
		s.fan_on = (mode == 4'h6);
		s.fan_lock = (mode == 4'h6);
		// Encoder only stalls in its fault mode
		if (mode != 4'h7)
			enc_r = ~enc_r;
		s.encoder = enc_r;
		s.lift_up = {mode == 4'hB, mode == 4'hA};
		s.lowering[0] = (mode == 4'hC);
		s.lift_sense[0] = (mode == 4'hC);
		s.lct_lowering = (mode == 4'hD);
		s.tray_set = tray_in;
		s.overload = {2{mode == 4'hE}};
		status <= s;
	end

endmodule : status_model

`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench: one fault mode per run, reset between runs.
// Assumes status_model and the supervisor with shortened timers.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ********************************************************
	// Set-up
	// ********************************************************
	localparam int XF = 10;
	localparam int LK = 12;
	localparam int FN = 14;
	localparam int EN = 16;
	localparam int CL = 18;
	localparam int LF = 20;
	localparam int LW = 22;
	localparam int LC = 24;

	logic                           mclk    = 1'b0;
	logic                           rst     = 1'b1;
	logic [3:0]                     mode    = 4'h0;
	logic [1:0]                     tray_in = 2'h0;
	fault_pkg::status_in_t          status;
	logic                           fault_valid;
	logic [fault_pkg::CODE_W-1:0]   service_call_code;
	logic [1:0]                     tray_reset_req;
	int                             n_fail    = 0;
	int                             cmp_count = 0;
	int                             seed      = 32'hB1AC;
	int                             lat;
	int                             k;

	always #25 mclk = ~mclk;

	status_model u_model (
		.mclk    (mclk),
		.mode    (mode),
		.tray_in (tray_in),
		.status  (status)
	);

	machine_fault_supervisor #(
		.CYC_XFER (XF), .CYC_LOCK (LK), .CYC_FAN (FN), .CYC_ENC (EN),
		.CYC_COLL (CL), .CYC_LIFT (LF), .CYC_LOWER (LW), .CYC_LCT (LC)
	) DUT (
		.mclk              (mclk),
		.rst               (rst),
		.status            (status),
		.fault_valid       (fault_valid),
		.service_call_code (service_call_code),
		.tray_reset_req    (tray_reset_req)
	);

	// ********************************************************
	// Expectations and helpers
	// ********************************************************
	// Code each mode must latch; mode F hits 401 and 402 together
	function automatic logic [31:0] exp_code(input logic [3:0] m);
		case (m)
			4'h1, 4'hF: return 32'h191;
			4'h2: return 32'h192;
			4'h3: return 32'h1AE;
			4'h4: return 32'h1B8;
			4'h5: return 32'h1B9;
			4'h6: return 32'h1EA;
			4'h7: return 32'h1EF;
			4'h8: return 32'h1F0;
			4'h9: return 32'h1F1;
			4'hB: return 32'h1F6;
			default: return 32'h1F5;
		endcase
	endfunction : exp_code

	// Timer length of each mode, 0 for the untimed checks
	function automatic int exp_n(input logic [3:0] m);
		case (m)
			4'h1, 4'h2, 4'hF: return XF;
			4'h4, 4'h5: return LK;
			4'h6: return FN;
			4'h7: return EN;
			4'h9: return CL;
			4'hA, 4'hB: return LF;
			4'hC: return LW;
			4'hD: return LC;
			default: return 0;
		endcase
	endfunction : exp_n

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick

	task automatic do_reset();
		rst = 1'b1;
		mode = 4'h0;
		tray_in = 2'h0;
		tick(3);
		rst = 1'b0;
		tick(3);
	endtask : do_reset

	// Two sync flops plus model drive give N+3 edges from mode, 4 for the untimed checks
	task automatic run(input logic [3:0] m);
		mode = m;
		lat = 0;
		while (fault_valid !== 1'b1 && lat < 200) begin
			tick(1);
			lat++;
		end
		check("code", 32'(service_call_code), exp_code(m));
		check("latency", 32'(lat >= exp_n(m) + 3 && lat <= exp_n(m) + 5), 1);
		mode = 4'h0;
		tick(6);
		check("held code", 32'(service_call_code), exp_code(m));
	endtask : run

	// Overloaded tray is pushed in, then pulled out again
	task automatic insert(input int t);
		tray_in[t] = 1'b1;
		tick(8);
		tray_in[t] = 1'b0;
		tick(4);
	endtask : insert

	// ********************************************************
	// Scenarios
	// ********************************************************
	initial begin
		do_reset();
		tick(40);
		check("idle", 32'(fault_valid), 0);
		for (k = 1; k < 16; k++) begin
			if (k != 14) begin
				do_reset();
				run(4'(k));
			end
		end
		// Short random dropouts must not add up toward the limit
		for (k = 0; k < 4; k++) begin
			do_reset();
			mode = 4'h9;
			tick(2 + ($unsigned($random(seed)) % 12));
			mode = 4'h0;
			tick(3);
			mode = 4'h9;
			tick(2 + ($unsigned($random(seed)) % 12));
			mode = 4'h0;
			tick(3);
			check("dropout", 32'(fault_valid), 0);
			run(4'h9);
		end
		// Tray 1 sees a power cycle after two insertions, tray 2 not
		for (k = 0; k < 2; k++) begin
			do_reset();
			mode = 4'hE;
			insert(k);
			check("reset req", 32'(tray_reset_req[k]), 1);
			check("no code", 32'(fault_valid), 0);
			insert(k);
			// After the power cycle tray 1 starts over: request, then count
			if (k == 0) begin
				do_reset();
				mode = 4'hE;
				insert(k);
				insert(k);
			end
			insert(k);
			check("early", 32'(fault_valid), 0);
			insert(k);
			check("tray code", 32'(service_call_code),
				(k == 1) ? 32'h1F6 : 32'h1F5);
		end
		end_sim();
	end

	// Hang guard, several times the expected run length
	initial begin
		#500_000;
		n_fail++;
		end_sim();
	end

endmodule : tb

`default_nettype wire
